// [hdl/ocs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - every output has a power-down bit, default 0 powered up, 1 down
// - channel format bit defaults 0 for LVDS, 1 selects LVPECL
// - aux format field defaults 10; 00 LVDS, 01 LVPECL, 1x CMOS
// - six enables, default 0, gate the six latched events onto the pin
// - synthesizer lock latch reads 0 after any lock loss since clear
// - writing 1 to a latched bit clears it and its pending interrupt
// - reference latch reads 0 if reference lost since clear
// - holdover latch reads 0 if holdover entered since clear
// - live status follows conditions; select bit shows chosen input
module ocs_regs (
  input  wire logic        sys_clk,        // system clock
  input  wire logic        arst_n,         // async reset, active low
  input  wire logic        clk_en,         // freezes all state when low
  input  wire logic        spi_sclk,       // serial port clock pin
  input  wire logic        spi_cs_n,       // serial port select pin
  input  wire logic        spi_sdi,        // serial data in pin
  output logic             spi_sdo,        // serial data out
  output logic             spi_sdo_oe_n,   // low while driving sdo
  input  wire logic        synth_lock_n,   // synth pll lost lock, active low live
  input  wire logic        jit_lock_n,     // jitter pll lost lock, active low live
  input  wire logic        ref_ok,         // reference present
  input  wire logic        hold_n,         // low while in holdover
  input  wire logic [1:0]  input_ok,       // input activity, 1 = active
  input  wire logic        selected_input_live, // chosen input
  input  wire logic        synth_calibration_active, // calibration running
  output logic [9:0]       output_powerdown,  // channel power-down
  output logic [9:0]       channel_style,     // channel format, 1 = lvpecl
  output logic [19:0]      channel_amp,       // channel amplitude codes
  output logic             aux_powerdown,     // aux power-down
  output logic [1:0]       aux_style,         // aux format code
  output logic [1:0]       aux_amp,           // aux amplitude code
  output logic             interrupt_out_n    // interrupt, active low
);
  localparam int NUM_CFG = ocs_pkg::NUM_CH + 1;
  typedef struct packed {
    logic [2:0]  s1;   // first sync stage sclk, cs_n, sdi
    logic [2:0]  s2;   // second sync stage
    logic [13:0] c1;   // first sync stage of status inputs
    logic [13:0] c2;   // second sync stage
    logic [NUM_CFG*8-1:0] cfg;
    logic [5:0]  ie;
    logic [5:0]  ls;   // 1 = no event
    logic [7:0]  live;
    logic [7:0]  cal;
    logic        irq_n;
    logic [9:0]  pd;
    logic [9:0]  sty;
    logic [19:0] amp;
    logic        apd;
    logic [1:0]  asty;
    logic [1:0]  aamp;
  } ocs_regs_state_t;
  localparam logic [7:0] CFG_ADDR [NUM_CFG] = '{ocs_pkg::ADDR_A0, ocs_pkg::ADDR_A1,
    ocs_pkg::ADDR_A2, ocs_pkg::ADDR_B0, ocs_pkg::ADDR_B1, ocs_pkg::ADDR_B2,
    ocs_pkg::ADDR_C0, ocs_pkg::ADDR_C1, ocs_pkg::ADDR_D0, ocs_pkg::ADDR_D1,
    ocs_pkg::ADDR_AUX};

  ocs_regs_state_t s_q, s_d;
  logic [7:0] p_addr;
  logic [7:0] p_wdata;
  logic       p_wr;
  logic [7:0] p_rdata;
  logic [5:0] evt;

  // ---------------------------------------------------------------
  // serial command port
  // ---------------------------------------------------------------
  ocs_serial_port u_port (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .sclk_s   (s_q.s2[2]),
    .cs_n_s   (s_q.s2[1]),
    .sdi_s    (s_q.s2[0]),
    .rdata    (p_rdata),
    .addr     (p_addr),
    .wdata    (p_wdata),
    .wr_stb   (p_wr),
    .sdo      (spi_sdo),
    .sdo_oe_n (spi_sdo_oe_n)
  );

  // index of a configuration register, NUM_CFG when unmapped
  function automatic int cfg_index(input logic [7:0] a);
    int r;
    r = NUM_CFG;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (a == CFG_ADDR[i]) r = i;
    end
    return r;
  endfunction

  // writable bit mask of a configuration register
  function automatic logic [7:0] cfg_mask(input int i);
    return (i == NUM_CFG - 1) ? ocs_pkg::MASK_AUX : ocs_pkg::MASK_CH;
  endfunction

  // ---------------------------------------------------------------
  // read mux, reserved bits read zero
  // ---------------------------------------------------------------
  always_comb begin
    int k;
    k = cfg_index(p_addr);
    p_rdata = 8'h00;
    if (k < NUM_CFG) p_rdata = s_q.cfg[k*8 +: 8];
    else if (p_addr == ocs_pkg::ADDR_IE) p_rdata = {2'b00, s_q.ie};
    else if (p_addr == ocs_pkg::ADDR_LS) p_rdata = {2'b00, s_q.ls};
    else if (p_addr == ocs_pkg::ADDR_ST) p_rdata = s_q.live;
    else if (p_addr == ocs_pkg::ADDR_CAL) p_rdata = s_q.cal;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    int k;
    k = cfg_index(p_addr);
    s_d = s_q;
    s_d.s1 = {spi_sclk, spi_cs_n, spi_sdi};
    s_d.s2 = s_q.s1;
    s_d.c1 = {selected_input_live, synth_calibration_active, synth_lock_n,
              jit_lock_n, ref_ok, hold_n, input_ok, 6'h00};
    s_d.c2 = s_q.c1;
    // raw events: bit order lolf, lolv, ref, hold, in1, in0
    evt = ~s_q.c2[11:6];
    // configuration writes keep reserved bits at zero
    if (p_wr && k < NUM_CFG) s_d.cfg[k*8 +: 8] = p_wdata & cfg_mask(k);
    if (p_wr && p_addr == ocs_pkg::ADDR_IE) s_d.ie = p_wdata[5:0];
    // write 1 clears, a simultaneous event wins
    if (p_wr && p_addr == ocs_pkg::ADDR_LS) s_d.ls = s_q.ls | p_wdata[5:0];
    s_d.ls = s_d.ls & ~evt;
    s_d.live = {1'b0, s_q.c2[13], s_q.c2[11:6]};
    s_d.cal = {5'h00, s_q.c2[12], 2'b00};
    s_d.irq_n = ~|(s_q.ie & ~s_q.ls);
    // decoded field outputs
    for (int i = 0; i < ocs_pkg::NUM_CH; i++) begin
      s_d.pd[i] = s_q.cfg[i*8 + ocs_pkg::POS_PD];
      s_d.sty[i] = s_q.cfg[i*8 + ocs_pkg::POS_STYLE];
      s_d.amp[i*2 +: 2] = s_q.cfg[i*8 + ocs_pkg::POS_AMP +: 2];
    end
    s_d.apd = s_q.cfg[(NUM_CFG-1)*8 + ocs_pkg::POS_PD];
    s_d.asty = s_q.cfg[(NUM_CFG-1)*8 + ocs_pkg::POS_AUXSTY +: 2];
    s_d.aamp = s_q.cfg[(NUM_CFG-1)*8 + ocs_pkg::POS_AMP +: 2];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // status sync stages start at their no-event levels, so no false event follows reset
      s_q <= '{s1: 3'b010, s2: 3'b010,
               c1: {2'b00, ocs_pkg::RST_LS, 6'h00}, c2: {2'b00, ocs_pkg::RST_LS, 6'h00},
               cfg: {ocs_pkg::RST_AUX, {ocs_pkg::NUM_CH{ocs_pkg::RST_CH}}},
               ie: ocs_pkg::RST_IE, ls: ocs_pkg::RST_LS, live: 8'h00,
               cal: 8'h00, irq_n: 1'b1, pd: 10'h000, sty: 10'h000,
               amp: {ocs_pkg::NUM_CH{2'b01}}, apd: 1'b0, asty: 2'b10,
               aamp: 2'b00};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign output_powerdown = s_q.pd;
  assign channel_style = s_q.sty;
  assign channel_amp = s_q.amp;
  assign aux_powerdown = s_q.apd;
  assign aux_style = s_q.asty;
  assign aux_amp = s_q.aamp;
  assign interrupt_out_n = s_q.irq_n;
endmodule
`default_nettype wire

// [hdl/ocs_pkg.sv]
package ocs_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_A0   = 8'h28;
  localparam logic [7:0] ADDR_A1   = 8'h29;
  localparam logic [7:0] ADDR_A2   = 8'h2A;
  localparam logic [7:0] ADDR_B0   = 8'h30;
  localparam logic [7:0] ADDR_B1   = 8'h31;
  localparam logic [7:0] ADDR_B2   = 8'h32;
  localparam logic [7:0] ADDR_C0   = 8'h38;
  localparam logic [7:0] ADDR_C1   = 8'h39;
  localparam logic [7:0] ADDR_D0   = 8'h40;
  localparam logic [7:0] ADDR_D1   = 8'h41;
  localparam logic [7:0] ADDR_AUX  = 8'h4B;
  localparam logic [7:0] ADDR_IE   = 8'h4C;
  localparam logic [7:0] ADDR_LS   = 8'h50;
  localparam logic [7:0] ADDR_ST   = 8'h51;
  localparam logic [7:0] ADDR_CAL  = 8'h53;
  localparam int         NUM_CH    = 10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_PD      = 7;
  localparam int POS_STYLE   = 4;
  localparam int POS_AUXSTY  = 4;
  localparam int POS_AMP     = 2;
  localparam int POS_SEL     = 6;
  localparam int POS_CAL     = 2;
  localparam int NUM_EVT     = 6;
  // ---------------------------------------------------------------
  // reset values and writable bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CH    = 8'h04;  // powered up, lvds, amp 01
  localparam logic [7:0] RST_AUX   = 8'h20;  // powered up, cmos 10, amp 00
  localparam logic [7:0] MASK_CH   = 8'h9C;
  localparam logic [7:0] MASK_AUX  = 8'hBC;
  localparam logic [5:0] RST_IE    = 6'h00;
  localparam logic [5:0] RST_LS    = 6'h3F;  // no event seen
  // serial port command bit: 1 = read
  localparam int SPI_BITS    = 16;
  localparam logic [3:0] SPI_LAST = 4'hF;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_SHFT = 3'b010,
    SP_DONE = 3'b100
  } ocs_sp_t;
endpackage

// [hdl/ocs_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
// serial command port: 1 r/w bit, 7 address bits, 8 data bits, msb first
module ocs_serial_port (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       arst_n,    // async reset, active low
  input  wire logic       clk_en,    // freezes state when low
  input  wire logic       sclk_s,    // synchronised serial clock
  input  wire logic       cs_n_s,    // synchronised chip select, active low
  input  wire logic       sdi_s,     // synchronised serial data in
  input  wire logic [7:0] rdata,     // read data for address
  output logic [7:0]      addr,      // register address
  output logic [7:0]      wdata,     // write data
  output logic            wr_stb,    // one-cycle write pulse
  output logic            sdo,       // serial data out
  output logic            sdo_oe_n   // low while driving sdo
);
  typedef struct packed {
    ocs_pkg::ocs_sp_t st;
    logic [3:0]       cnt;
    logic             sclk_p;
    logic             rd;
    logic [7:0]       addr;
    logic [7:0]       sh;
    logic [7:0]       tx;
    logic             wr;
    logic             sdo;
    logic             oe_n;
  } ocs_sp_state_t;
  ocs_sp_state_t s_q, s_d;
  logic rise;
  logic fall;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    rise = sclk_s & ~s_q.sclk_p;
    fall = ~sclk_s & s_q.sclk_p;
    s_d.sclk_p = sclk_s;
    s_d.wr = 1'b0;
    case (s_q.st)
      ocs_pkg::SP_IDLE: begin
        s_d.cnt = 4'h0;
        s_d.oe_n = 1'b1;
        if (!cs_n_s) s_d.st = ocs_pkg::SP_SHFT;
      end
      ocs_pkg::SP_SHFT: begin
        if (cs_n_s) begin
          s_d.st = ocs_pkg::SP_IDLE;
        end else if (rise) begin
          s_d.sh = {s_q.sh[6:0], sdi_s};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == 4'h0) s_d.rd = sdi_s;
          if (s_q.cnt == 4'h7) s_d.addr = {1'b0, s_q.sh[5:0], sdi_s};
          if (s_q.cnt == ocs_pkg::SPI_LAST) begin
            s_d.wr = ~s_q.rd;
            s_d.st = ocs_pkg::SP_DONE;
          end
        end else if (fall && s_q.rd && s_q.cnt >= 4'h8) begin
          s_d.oe_n = 1'b0;
          s_d.sdo = s_q.tx[7];
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
        // load read data once the address is complete
        if (s_q.cnt == 4'h8 && !rise && !fall && s_q.oe_n) s_d.tx = rdata;
      end
      ocs_pkg::SP_DONE: begin
        if (cs_n_s) s_d.st = ocs_pkg::SP_IDLE;
      end
      default: s_d.st = ocs_pkg::SP_IDLE;
    endcase
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: ocs_pkg::SP_IDLE, cnt: 4'h0, sclk_p: 1'b0, rd: 1'b0,
               addr: 8'h00, sh: 8'h00, tx: 8'h00, wr: 1'b0, sdo: 1'b0,
               oe_n: 1'b1};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign addr = s_q.addr;
  assign wdata = s_q.sh;
  assign wr_stb = s_q.wr;
  assign sdo = s_q.sdo;
  assign sdo_oe_n = s_q.oe_n;
endmodule
`default_nettype wire

// [tb/ocs_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the output and status register bank
module ocs_regs_checker (
  input wire logic        sys_clk,          // clock
  input wire logic        arst_n,           // reset
  input wire logic        spi_cs_n,         // select
  input wire logic        synth_lock_n,     // event
  input wire logic        jit_lock_n,       // event
  input wire logic        ref_ok,           // event
  input wire logic        hold_n,           // event
  input wire logic [1:0]  input_ok,         // event
  input wire logic [9:0]  output_powerdown, // field
  input wire logic [9:0]  channel_style,    // field
  input wire logic [19:0] channel_amp,      // field
  input wire logic        aux_powerdown,    // field
  input wire logic [1:0]  aux_style,        // field
  input wire logic [1:0]  aux_amp,          // field
  input wire logic        interrupt_out_n   // irq
);
  logic [3:0] quiet_q;
  logic [3:0] idle_q;
  wire        calm = spi_cs_n & synth_lock_n & jit_lock_n & ref_ok & hold_n & (&input_ok);
  // count cycles with no port traffic (idle_q) and with no port traffic and no event condition (quiet_q)
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_q <= 4'h0;
      idle_q  <= 4'h0;
    end else begin
      quiet_q <= !calm ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
      idle_q  <= !spi_cs_n ? 4'h0 : ((idle_q == 4'hF) ? idle_q : idle_q + 4'h1);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_PD_RST: assert property ($rose(arst_n) |-> !output_powerdown && !aux_powerdown)
    else $error("power-down set after reset");
  AST_AMP_RST: assert property ($rose(arst_n) |-> channel_amp == {10{2'h1}} && aux_amp == 2'h0)
    else $error("amplitude default wrong");
  AST_STYLE_RST: assert property ($rose(arst_n) |-> channel_style == 10'h000)
    else $error("channel format default wrong");
  AST_AUX_RST: assert property ($rose(arst_n) |-> aux_style == 2'h2)
    else $error("aux format default wrong");
  AST_IRQ_RST: assert property ($rose(arst_n) |-> interrupt_out_n)
    else $error("interrupt active after reset");
  AST_CFG_HOLD: assert property (idle_q == 4'hF |-> $stable({output_powerdown, channel_style,
    channel_amp, aux_powerdown, aux_style, aux_amp}))
    else $error("output field moved without a write");
  AST_IRQ_FALL: assert property ($fell(interrupt_out_n) |-> quiet_q < 4'hA)
    else $error("interrupt raised without cause");
  AST_IRQ_RISE: assert property ($rose(interrupt_out_n) |-> idle_q < 4'hA)
    else $error("interrupt withdrawn without a write");
  AST_IRQ_HOLD: assert property (quiet_q == 4'hF |=> $stable(interrupt_out_n))
    else $error("interrupt moved while quiet");
  COV_FALL: cover property ($fell(interrupt_out_n));
  COV_RISE: cover property ($rose(interrupt_out_n));
  COV_EVT: cover property (!synth_lock_n ##1 synth_lock_n);
endmodule
bind ocs_regs ocs_regs_checker u_chk (
  .sys_clk          (sys_clk),
  .arst_n           (arst_n),
  .spi_cs_n         (spi_cs_n),
  .synth_lock_n     (synth_lock_n),
  .jit_lock_n       (jit_lock_n),
  .ref_ok           (ref_ok),
  .hold_n           (hold_n),
  .input_ok         (input_ok),
  .output_powerdown (output_powerdown),
  .channel_style    (channel_style),
  .channel_amp      (channel_amp),
  .aux_powerdown    (aux_powerdown),
  .aux_style        (aux_style),
  .aux_amp          (aux_amp),
  .interrupt_out_n  (interrupt_out_n)
);
`default_nettype wire

// [tb/ocs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// serial port host: r/w bit, 7 address bits, 8 data bits, msb first
module ocs_host_model (
  input wire logic sys_clk,      // clock
  input wire logic spi_sdo,      // read data
  output logic     spi_sclk,     // serial clock, idle low
  output logic     spi_cs_n,     // select
  output logic     spi_sdi       // write data
);
  localparam int HALF = 8;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end
  // one whole frame; read bits sampled on the rising clock
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(posedge sys_clk);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= w[i];
      repeat (HALF) @(posedge sys_clk);
      spi_sclk <= 1'b1;
      if (i < 8) q[i] = spi_sdo;
      repeat (HALF) @(posedge sys_clk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    spi_sdi  <= ~spi_sdi;  // released line shows no stale bit
    repeat (HALF) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [tb/output_cfg_status_irq_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module output_cfg_status_irq_regs_tb;
  logic        sys_clk, arst_n, sclk, cs_n, sdi, sdo, sel, cal, irq_n, aux_pd, en;
  logic [5:0]  bad;
  logic [9:0]  pd, sty;
  logic [19:0] amp;
  logic [1:0]  aux_sty, aux_amp;
  logic [7:0]  got;
  int          errors, checks, ie_m, ls_m;
  int          mdl [128];
  int          cfg_a [11] = '{8'h28, 8'h29, 8'h2A, 8'h30, 8'h31, 8'h32, 8'h38, 8'h39,
                              8'h40, 8'h41, 8'h4B};
  // design under a bench-driven clock enable; bad[i] raises event i
  ocs_regs u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(en), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(), .synth_lock_n(~bad[5]),
    .jit_lock_n(~bad[4]), .ref_ok(~bad[3]), .hold_n(~bad[2]), .input_ok(~bad[1:0]),
    .selected_input_live(sel), .synth_calibration_active(cal), .output_powerdown(pd),
    .channel_style(sty), .channel_amp(amp), .aux_powerdown(aux_pd), .aux_style(aux_sty),
    .aux_amp(aux_amp), .interrupt_out_n(irq_n));
  ocs_host_model u_host (.sys_clk(sys_clk), .spi_sdo(sdo), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // expected read value of one address
  function automatic int exp_rd(int a);
    if (a == 8'h4B) return mdl[a] & 8'hBC;
    foreach (cfg_a[k]) if (cfg_a[k] == a) return mdl[a] & 8'h9C;
    case (a)
      8'h4C: return ie_m;
      8'h50: return ls_m;
      8'h51: return {25'h0, sel, ~bad};
      8'h53: return {29'h0, cal, 2'h0};
      default: return 0;
    endcase
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    u_host.xfer(1'b0, a[6:0], d, got);
    if (a == 8'h4C) ie_m = d & 8'h3F;
    else if (a == 8'h50) ls_m = ls_m | (d & 8'h3F);
    else if (a < 8'h4C) mdl[a] = d;
  endtask
  task automatic rdc(logic [7:0] a);
    u_host.xfer(1'b1, a[6:0], 8'h00, got);
    chk(got, exp_rd(a));
  endtask
  task automatic chk_outs();
    logic [9:0]  p, s;
    logic [19:0] m;
    for (int c = 0; c < 10; c++) begin
      p[c] = mdl[cfg_a[c]][7];
      s[c] = mdl[cfg_a[c]][4];
      m[2*c +: 2] = mdl[cfg_a[c]][3:2];
    end
    chk({pd, sty}, {p, s});
    chk({amp, aux_pd, aux_sty, aux_amp}, {m, mdl[8'h4B][7], mdl[8'h4B][5:2]});
  endtask
  task automatic evt(int i);
    @(posedge sys_clk);
    bad[i] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    bad[i] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ls_m = ls_m & ~(1 << i);
  endtask
  task automatic chk_irq();
    chk(irq_n, (ie_m & ~ls_m & 8'h3F) == 0);
  endtask
  // watchdog
  initial begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    en = 1'b1;
    bad = 6'h00;
    sel = 1'b0;
    cal = 1'b0;
    ie_m = 0;
    ls_m = 8'h3F;
    foreach (mdl[k]) mdl[k] = 8'h04;
    mdl[8'h4B] = 8'h20;
    void'($urandom(73));
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_outs();
    foreach (cfg_a[k]) rdc(cfg_a[k]);
    rdc(8'h4C);
    rdc(8'h50);
    sel <= 1'($urandom);
    cal <= 1'($urandom);
    wr(8'h51, 8'hFF);
    rdc(8'h51);
    rdc(8'h53);
    foreach (cfg_a[k]) wr(cfg_a[k], 8'($urandom));
    wr(8'h2B, 8'hFF);
    foreach (cfg_a[k]) rdc(cfg_a[k]);
    rdc(8'h2B);
    chk_outs();
    for (int i = 0; i < 6; i++) begin
      evt(i);
      chk_irq();
      rdc(8'h50);
      wr(8'h4C, 8'(1 << i));
      chk_irq();
      wr(8'h50, 8'(1 << i));
      chk_irq();
      rdc(8'h50);
      wr(8'h4C, 8'h00);
    end
    // an event while the clock enable is low must leave no trace
    en <= 1'b0;
    bad[5] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    bad[5] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    en <= 1'b1;
    rdc(8'h50);
    wr(8'h4C, 8'h3F);
    evt(0);
    evt(5);
    wr(8'h50, 8'h01);
    chk_irq();
    wr(8'h4C, 8'h1F);
    chk_irq();
    wr(8'h50, 8'h3F);
    rdc(8'h50);
    final_report();
  end
endmodule
`default_nettype wire
